// ---- hdl/erc_cfg.svh ----
// Constants for the auxiliary external regulator control block
`ifndef ERC_CFG_SVH
`define ERC_CFG_SVH

// Chip operating mode codes on the sbcMode input
`define ERC_MODE_W        3
`define ERC_MODE_INIT     3'h0
`define ERC_MODE_NORMAL   3'h1
`define ERC_MODE_STOP     3'h2
`define ERC_MODE_SLEEP    3'h3
`define ERC_MODE_RESTART  3'h4
`define ERC_MODE_FAILSAFE 3'h5

// Reset values of the control bits
`define ERC_RST_BIT       1'h0

`endif

// ---- hdl/erc_pkg.sv ----
// Types for the auxiliary external regulator control block
package erc_pkg;

   // Configuration state, Gray coded along unconfigured to locked
   typedef enum logic [1:0] {
      ERC_UNCONF     = 2'h0,
      ERC_STANDALONE = 2'h1,
      ERC_LOADSHARE  = 2'h3
   } erc_cfg_e;

   // Main block state
   typedef struct packed {
      erc_cfg_e cfg;
      logic     standaloneEnable;
      logic     loadshareEnable;
      logic     loadshareStopKeep;
      logic     keepOnLowSupply;
      logic     serialAccessFault;
   } erc_state_s;

   // Sticky flag state
   typedef struct packed {
      logic flag;
   } erc_flag_s;

endpackage

// ---- hdl/erc_sticky_flag.sv ----
// Sticky status flag, set by hardware and cleared by a host write
`timescale 1ns/1ps
`default_nettype none
module erc_sticky_flag (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic setEvent,
   input  wire logic clearWr,
   input  wire logic condActive,
   output logic      flag
);
   erc_pkg::erc_flag_s state_reg;
   erc_pkg::erc_flag_s state_next;

   // Set wins over clear; a clear is refused while the condition is present
   always_comb begin
      state_next = state_reg;
      if (clearWr && !condActive) begin
         state_next.flag = 1'h0;
      end
      if (setEvent) begin
         state_next.flag = 1'h1;
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign flag = state_reg.flag;
endmodule
`default_nettype wire

// ---- hdl/erc_regulator_ctrl.sv ----
// Configuration lock, mode enabling and status flags of the auxiliary regulator
// Notes on behaviour
// R1: First standalone set with loadshare clear locks standalone
// R2: Standalone locked: change attempts ignored, no fault
// R3: Standalone shunt trip limits current, sets overcurrent
// R4: Overcurrent flag holds until host clears it
// R5: Standalone undervoltage sets the undervoltage flag
// R6: First loadshare set locks; later changes raise fault
// R7: Loadshare without stop keep switches off in Stop
// R8: Loadshare resumes automatically back in Normal mode
// R9: Loadshare active in Normal, in Stop if kept
// R10: Loadshare never sets the undervoltage flag
// R11: Loadshare regulator off in Fail-Safe mode
// R12: Loadshare has no limiting and no overcurrent flag
// R13: Host should not enable an unused regulator
// R14: Supply undervoltage turns off unless keep-on set
// R15: Clear during active overcurrent leaves flag set
`timescale 1ns/1ps
`default_nettype none
`include "erc_cfg.svh"
module erc_regulator_ctrl (
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic [`ERC_MODE_W-1:0]   sbcMode,
   input  wire logic                     cfgWr,
   input  wire logic                     wrStandaloneEnable,
   input  wire logic                     wrLoadshareEnable,
   input  wire logic                     wrLoadshareStopKeep,
   input  wire logic                     wrKeepOnLowSupply,
   input  wire logic                     ocClearWr,
   input  wire logic                     uvClearWr,
   input  wire logic                     shuntTrip,
   input  wire logic                     auxUvDetect,
   input  wire logic                     supplyUv,
   output logic                          standaloneEnable,
   output logic                          loadshareEnable,
   output logic                          loadshareStopKeep,
   output logic                          keepOnLowSupply,
   output logic                          cfgLocked,
   output logic                          cfgIsLoadshare,
   output logic                          serialAccessFault,
   output logic                          regulatorOn,
   output logic                          currentLimit,
   output logic                          auxOvercurrentFlag,
   output logic                          auxUndervoltageFlag
);
   erc_pkg::erc_state_s state_reg;
   erc_pkg::erc_state_s state_next;
   logic                isStandalone;
   logic                isLoadshare;
   logic                modeAllows;
   logic                supplyAllows;
   logic                ocEvent;
   logic                uvEvent;

   assign isStandalone = (state_reg.cfg == erc_pkg::ERC_STANDALONE);
   assign isLoadshare  = (state_reg.cfg == erc_pkg::ERC_LOADSHARE);

   // Configuration lock and control bit updates
   always_comb begin
      state_next = state_reg;
      state_next.serialAccessFault = 1'h0;
      if (cfgWr) begin
         state_next.loadshareStopKeep = wrLoadshareStopKeep;
         state_next.keepOnLowSupply   = wrKeepOnLowSupply;
         case (state_reg.cfg)
            erc_pkg::ERC_UNCONF: begin
               if (wrLoadshareEnable) begin
                  state_next.cfg             = erc_pkg::ERC_LOADSHARE; // R6
                  state_next.loadshareEnable = 1'h1;
               end else if (wrStandaloneEnable) begin
                  state_next.cfg              = erc_pkg::ERC_STANDALONE; // R1
                  state_next.standaloneEnable = 1'h1;
               end
            end
            erc_pkg::ERC_STANDALONE: begin
               // Only on/off remains; a loadshare request is dropped silently
               state_next.standaloneEnable = wrStandaloneEnable; // R1 R2
            end
            erc_pkg::ERC_LOADSHARE: begin
               if (!wrLoadshareEnable || wrStandaloneEnable) begin
                  state_next.serialAccessFault = 1'h1; // R6
               end
            end
            default: begin
               state_next.cfg = erc_pkg::ERC_UNCONF;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg.cfg               <= erc_pkg::ERC_UNCONF;
         state_reg.standaloneEnable  <= `ERC_RST_BIT;
         state_reg.loadshareEnable   <= `ERC_RST_BIT;
         state_reg.loadshareStopKeep <= `ERC_RST_BIT;
         state_reg.keepOnLowSupply   <= `ERC_RST_BIT;
         state_reg.serialAccessFault <= 1'h0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Mode dependent enabling per configuration
   always_comb begin
      modeAllows = 1'h0;
      if (isLoadshare) begin
         case (sbcMode)
            `ERC_MODE_NORMAL:  modeAllows = 1'h1; // R8 R9
            `ERC_MODE_STOP:    modeAllows = state_reg.loadshareStopKeep; // R7 R9
            `ERC_MODE_RESTART: modeAllows = 1'h1;
            `ERC_MODE_FAILSAFE: modeAllows = 1'h0; // R11
            default:           modeAllows = 1'h0;
         endcase
      end else if (isStandalone) begin
         case (sbcMode)
            `ERC_MODE_INIT:     modeAllows = 1'h0;
            `ERC_MODE_FAILSAFE: modeAllows = 1'h0;
            default:            modeAllows = state_reg.standaloneEnable;
         endcase
      end
   end

   // Supply undervoltage switch-off unless kept on
   assign supplyAllows = !supplyUv || state_reg.keepOnLowSupply; // R14
   assign regulatorOn  = modeAllows && supplyAllows;

   // Limiting and flag events only exist in standalone use
   assign currentLimit = isStandalone && regulatorOn && shuntTrip; // R3 R12
   assign ocEvent      = currentLimit; // R3 R12
   assign uvEvent      = isStandalone && regulatorOn && auxUvDetect; // R5 R10

   // Overcurrent flag, cleared only once the trip is gone
   erc_sticky_flag ocFlag (
      .mclk       (mclk),
      .rst        (rst),
      .setEvent   (ocEvent),
      .clearWr    (ocClearWr),
      .condActive (shuntTrip), // R4 R15
      .flag       (auxOvercurrentFlag)
   );

   // Undervoltage flag
   erc_sticky_flag uvFlag (
      .mclk       (mclk),
      .rst        (rst),
      .setEvent   (uvEvent),
      .clearWr    (uvClearWr),
      .condActive (1'h0),
      .flag       (auxUndervoltageFlag)
   );

   // Register-driven outputs
   assign standaloneEnable  = state_reg.standaloneEnable;
   assign loadshareEnable   = state_reg.loadshareEnable; // R7
   assign loadshareStopKeep = state_reg.loadshareStopKeep;
   assign keepOnLowSupply   = state_reg.keepOnLowSupply;
   assign cfgLocked         = (state_reg.cfg != erc_pkg::ERC_UNCONF);
   assign cfgIsLoadshare    = isLoadshare;
   assign serialAccessFault = state_reg.serialAccessFault;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_lockStandalone;
      (!cfgLocked && cfgWr && wrStandaloneEnable && !wrLoadshareEnable) |=> (cfgLocked && !cfgIsLoadshare);
   endproperty
   a_lockStandalone: assert property (p_lockStandalone) else $error("Standalone not locked"); // R1

   property p_standaloneNoFault;
      (cfgLocked && !cfgIsLoadshare && cfgWr) |=> (!serialAccessFault && !cfgIsLoadshare && cfgLocked);
   endproperty
   a_standaloneNoFault: assert property (p_standaloneNoFault) else $error("Standalone change faulted"); // R2

   property p_limitOnTrip;
      (cfgLocked && !cfgIsLoadshare && regulatorOn && shuntTrip) |-> currentLimit ##1 auxOvercurrentFlag;
   endproperty
   a_limitOnTrip: assert property (p_limitOnTrip) else $error("Overcurrent not flagged"); // R3

   property p_ocSticky;
      (auxOvercurrentFlag && !ocClearWr) |=> auxOvercurrentFlag;
   endproperty
   a_ocSticky: assert property (p_ocSticky) else $error("Overcurrent flag dropped"); // R4

   property p_ocClearBlocked;
      (auxOvercurrentFlag && ocClearWr && shuntTrip) |=> auxOvercurrentFlag;
   endproperty
   a_ocClearBlocked: assert property (p_ocClearBlocked) else $error("Flag cleared during trip"); // R15

   property p_lsFault;
      (cfgIsLoadshare && cfgWr && !wrLoadshareEnable) |=> (serialAccessFault && cfgIsLoadshare && loadshareEnable);
   endproperty
   a_lsFault: assert property (p_lsFault) else $error("Loadshare change not faulted"); // R6

   property p_lsStopOff;
      (cfgIsLoadshare && !loadshareStopKeep && sbcMode == `ERC_MODE_STOP) |-> (!regulatorOn && loadshareEnable);
   endproperty
   a_lsStopOff: assert property (p_lsStopOff) else $error("Loadshare on in Stop"); // R7

   property p_lsNormalOn;
      (cfgIsLoadshare && sbcMode == `ERC_MODE_NORMAL && !supplyUv) |-> regulatorOn;
   endproperty
   a_lsNormalOn: assert property (p_lsNormalOn) else $error("Loadshare off in Normal"); // R8 R9

   property p_lsNoFlags;
      cfgIsLoadshare ##1 cfgIsLoadshare |-> (!auxUndervoltageFlag && !auxOvercurrentFlag && !currentLimit);
   endproperty
   a_lsNoFlags: assert property (p_lsNoFlags) else $error("Loadshare raised a flag"); // R10 R12

   property p_failsafeOff;
      (sbcMode == `ERC_MODE_FAILSAFE) |-> !regulatorOn;
   endproperty
   a_failsafeOff: assert property (p_failsafeOff) else $error("Regulator on in Fail-Safe"); // R11

   property p_lowSupply;
      (supplyUv && !keepOnLowSupply) |-> !regulatorOn;
   endproperty
   a_lowSupply: assert property (p_lowSupply) else $error("Regulator on at low supply"); // R14

   property p_uvSet;
      (cfgLocked && !cfgIsLoadshare && regulatorOn && auxUvDetect) |=> auxUndervoltageFlag;
   endproperty
   a_uvSet: assert property (p_uvSet) else $error("Undervoltage not flagged"); // R5

   c_lockLs:    cover property (!cfgLocked ##1 cfgIsLoadshare);
   c_ocFlag:    cover property (auxOvercurrentFlag ##1 !auxOvercurrentFlag);
   c_stopKeep:  cover property (cfgIsLoadshare && loadshareStopKeep && sbcMode == `ERC_MODE_STOP && regulatorOn);
   c_lsFault:   cover property (serialAccessFault);
endmodule
`default_nettype wire

// ---- test/erc_host_model.sv ----
// Host model issuing control writes and flag clears
`timescale 1ns/1ps
`default_nettype none
module erc_host_model (
   input  wire logic mclk,
   output logic      cfgWr,
   output logic      wrSa,
   output logic      wrLs,
   output logic      wrSk,
   output logic      wrKo,
   output logic      ocClr,
   output logic      uvClr
);
   // Idle lines; nothing is enabled unless a test asks for it
   initial begin
      {cfgWr, wrSa, wrLs, wrSk, wrKo, ocClr, uvClr} = 7'h00;
   end
   // One-cycle control write; data shows inverted once released
   task automatic cfg(input logic sa, input logic ls, input logic sk, input logic ko);
      @(negedge mclk);
      {cfgWr, wrSa, wrLs, wrSk, wrKo} = {1'h1, sa, ls, sk, ko};
      @(negedge mclk);
      {cfgWr, wrSa, wrLs, wrSk, wrKo} = {1'h0, ~sa, ~ls, ~sk, ~ko};
   endtask
   // One-cycle clear pulse of the overcurrent or undervoltage flag
   task automatic clr(input logic oc);
      @(negedge mclk);
      {ocClr, uvClr} = {oc, ~oc};
      @(negedge mclk);
      {ocClr, uvClr} = 2'h0;
   endtask
endmodule
`default_nettype wire

// ---- test/test_erc_regulator_ctrl.sv ----
// Self-checking bench of the auxiliary regulator control
`timescale 1ns/1ps
`default_nettype none
`include "erc_cfg.svh"
module test_erc_regulator_ctrl;
   logic                   mclk = 1'h0;
   logic                   rst = 1'h1;
   logic                   shuntTrip = 1'h0;
   logic                   auxUvDetect = 1'h0;
   logic                   supplyUv = 1'h0;
   logic [`ERC_MODE_W-1:0] sbcMode = `ERC_MODE_NORMAL;
   logic                   cfgWr, wrSa, wrLs, wrSk, wrKo, ocClr, uvClr;
   logic                   saEn, lsEn, skEn, koEn, locked, isLs, fault, regOn, curLim, ocFlag, uvFlag;
   int                     num_errors = 0;
   int                     num_checks = 0;
   logic [31:0]            lfsr = 32'h6c11996a;

   // Clock at 100 ns period
   always #50 mclk = ~mclk;

   erc_host_model erc_host_model_i (.mclk(mclk), .cfgWr(cfgWr), .wrSa(wrSa), .wrLs(wrLs), .wrSk(wrSk),
      .wrKo(wrKo), .ocClr(ocClr), .uvClr(uvClr));

   erc_regulator_ctrl erc_regulator_ctrl_i (.mclk(mclk), .rst(rst), .sbcMode(sbcMode), .cfgWr(cfgWr),
      .wrStandaloneEnable(wrSa), .wrLoadshareEnable(wrLs), .wrLoadshareStopKeep(wrSk),
      .wrKeepOnLowSupply(wrKo), .ocClearWr(ocClr), .uvClearWr(uvClr), .shuntTrip(shuntTrip),
      .auxUvDetect(auxUvDetect), .supplyUv(supplyUv), .standaloneEnable(saEn), .loadshareEnable(lsEn),
      .loadshareStopKeep(skEn), .keepOnLowSupply(koEn), .cfgLocked(locked), .cfgIsLoadshare(isLs),
      .serialAccessFault(fault), .regulatorOn(regOn), .currentLimit(curLim),
      .auxOvercurrentFlag(ocFlag), .auxUndervoltageFlag(uvFlag));

   // Next value of the random sequence
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected regulator state by configuration, mode and supply
   function automatic logic exp_on(input logic ls, input logic en, input logic sk, input logic ko,
                                   input logic [`ERC_MODE_W-1:0] m, input logic vsLow);
      logic on;
      if (ls)
         on = (m == `ERC_MODE_NORMAL) || (m == `ERC_MODE_RESTART) || (sk && m == `ERC_MODE_STOP);
      else
         on = en && (m != `ERC_MODE_INIT) && (m != `ERC_MODE_FAILSAFE);
      return on && !(vsLow && !ko);
   endfunction

   // Compare and count
   task automatic check(input string name, input logic seen, input logic exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %b seen %b", name, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Synchronous reset held for 12 cycles
   task automatic do_reset();
      @(negedge mclk);
      rst = 1'h1;
      repeat (12) @(negedge mclk);
      rst = 1'h0;
   endtask

   // All modes in order, then random modes and supply dips
   task automatic sweep(input logic ls, input logic en, input logic sk, input logic ko, input int n);
      int m;
      for (int i = 0; i < n; i++) begin
         lfsr = next_rand(lfsr);
         m = (i < 6) ? i : lfsr % 6;
         @(negedge mclk);
         sbcMode = m[`ERC_MODE_W-1:0];
         supplyUv = (i >= 6) && lfsr[8];
         #10;
         check("regOn", regOn, exp_on(ls, en, sk, ko, sbcMode, supplyUv));
         check("isLs", isLs, ls);
      end
      @(negedge mclk);
      {sbcMode, supplyUv} = {`ERC_MODE_NORMAL, 1'h0};
   endtask

   // Watchdog
   initial begin
      #2000000;
      num_errors++;
      $display("test timed out");
      stop_test();
   end

   // Main sequence
   initial begin
      repeat (12) @(negedge mclk);
      rst = 1'h0;
      check("locked", locked, 1'h0);
      check("regOn", regOn, 1'h0);
      $display("test reset done");
      erc_host_model_i.cfg(1'h1, 1'h0, 1'h0, 1'h0);
      check("locked", locked, 1'h1);
      erc_host_model_i.cfg(1'h1, 1'h1, 1'h0, 1'h0);
      check("isLs", isLs, 1'h0);
      check("fault", fault, 1'h0);
      erc_host_model_i.cfg(1'h0, 1'h1, 1'h0, 1'h0);
      check("regOn", regOn, 1'h0);
      check("saEn", saEn, 1'h0);
      erc_host_model_i.cfg(1'h1, 1'h0, 1'h0, 1'h0);
      sweep(1'h0, 1'h1, 1'h0, 1'h0, 30);
      erc_host_model_i.cfg(1'h1, 1'h0, 1'h0, 1'h1);
      check("koEn", koEn, 1'h1);
      sweep(1'h0, 1'h1, 1'h0, 1'h1, 12);
      $display("test standalone done");
      shuntTrip = 1'h1;
      #10;
      check("curLim", curLim, 1'h1);
      @(negedge mclk);
      check("ocFlag", ocFlag, 1'h1);
      check("regOn", regOn, 1'h1);
      // Regulator off while the trip stays: no set event can hide a wrongly accepted clear
      sbcMode = `ERC_MODE_FAILSAFE;
      #10;
      check("curLim", curLim, 1'h0);
      erc_host_model_i.clr(1'h1);
      check("ocFlag", ocFlag, 1'h1);
      shuntTrip = 1'h0;
      sbcMode = `ERC_MODE_NORMAL;
      erc_host_model_i.clr(1'h1);
      check("ocFlag", ocFlag, 1'h0);
      auxUvDetect = 1'h1;
      @(negedge mclk);
      auxUvDetect = 1'h0;
      check("uvFlag", uvFlag, 1'h1);
      erc_host_model_i.clr(1'h0);
      check("uvFlag", uvFlag, 1'h0);
      $display("test flags done");
      do_reset();
      check("locked", locked, 1'h0);
      check("saEn", saEn, 1'h0);
      erc_host_model_i.cfg(1'h0, 1'h1, 1'h0, 1'h0);
      check("isLs", isLs, 1'h1);
      sweep(1'h1, 1'h0, 1'h0, 1'h0, 30);
      check("lsEn", lsEn, 1'h1);
      erc_host_model_i.cfg(1'h0, 1'h1, 1'h1, 1'h0);
      check("skEn", skEn, 1'h1);
      check("fault", fault, 1'h0);
      sweep(1'h1, 1'h0, 1'h1, 1'h0, 20);
      erc_host_model_i.cfg(1'h0, 1'h0, 1'h1, 1'h0);
      check("fault", fault, 1'h1);
      check("lsEn", lsEn, 1'h1);
      @(negedge mclk);
      check("fault", fault, 1'h0);
      erc_host_model_i.cfg(1'h1, 1'h1, 1'h1, 1'h0);
      check("fault", fault, 1'h1);
      check("isLs", isLs, 1'h1);
      {shuntTrip, auxUvDetect} = 2'h3;
      #10;
      check("curLim", curLim, 1'h0);
      @(negedge mclk);
      check("ocFlag", ocFlag, 1'h0);
      check("uvFlag", uvFlag, 1'h0);
      {shuntTrip, auxUvDetect} = 2'h0;
      $display("test loadshare done");
      stop_test();
   end
endmodule
`default_nettype wire
